// >>> src/jtag_char_port_cfg.svh
// Offsets, field positions, depths and thresholds of the character port
`ifndef JTAG_CHAR_PORT_CFG_SVH
`define JTAG_CHAR_PORT_CFG_SVH

// ----------------------------------------------------------------
// Register map (word index on the address port)
// ----------------------------------------------------------------
`define REG_CHAR_TRANSFER      1'h0
`define REG_IRQ_AND_FIFO_STATE 1'h1

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DATA_LSB        0
`define DATA_MSB        7
`define RX_VALID_BIT    15
`define COUNT_LSB       16
`define RX_IRQ_EN_BIT   0
`define TX_IRQ_EN_BIT   1
`define RX_IRQ_PEND_BIT 8
`define TX_IRQ_PEND_BIT 9
`define HOST_ACT_BIT    10

// ----------------------------------------------------------------
// Depths and thresholds
// ----------------------------------------------------------------
`define FIFO_AW         6
`define FIFO_DEPTH      7'h40
`define READ_THRESHOLD  7'h08
`define WRITE_THRESHOLD 7'h08

`endif

// >>> src/jtag_char_port_pkg.sv
// Types shared by the character port
`include "jtag_char_port_cfg.svh"

package jtag_char_port_pkg;

	typedef logic [`FIFO_AW:0] count_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} char_s;

	typedef struct packed {
		logic [`FIFO_AW-1:0]    rx_rd_ptr;
		logic [`FIFO_AW-1:0]    rx_wr_ptr;
		count_t                 rx_count;
		logic [`FIFO_AW-1:0]    tx_rd_ptr;
		logic [`FIFO_AW-1:0]    tx_wr_ptr;
		count_t                 tx_count;
		logic                   rx_irq_enable;
		logic                   tx_irq_enable;
		logic                   host_activity_flag;
		logic [31:0]            readdata;
		logic                   irq;
		char_s                  host_out;
		logic                   host_in_ready;
	} state_s;

endpackage : jtag_char_port_pkg

// >>> src/jtag_char_port_regs.sv
// Character port between processor registers and the debug-link host side
`timescale 1ns/1ps
`include "jtag_char_port_cfg.svh"

module jtag_char_port_regs
	import jtag_char_port_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// Register slave port
	input  wire logic        address,
	input  wire logic        chipselect,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             irq,
	// Host side, characters from host into read FIFO
	input  wire char_s       host_in,
	output logic             host_in_ready,
	// Host side, characters to host from write FIFO
	output char_s            host_out,
	input  wire logic        host_out_ready,
	// Host side status
	input  wire logic        host_poll,
	input  wire logic        host_no_more
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [7:0] rx_mem [0:`FIFO_DEPTH-1];
	logic [7:0] tx_mem [0:`FIFO_DEPTH-1];

	state_s s_q;
	state_s s_d;

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	logic   data_rd;
	logic   data_wr;
	logic   ctrl_wr;
	logic   rx_pop;
	logic   rx_push;
	logic   tx_push;
	logic   tx_pop;
	logic   rx_cond;
	logic   tx_cond;
	count_t rx_free;
	count_t tx_free;
	count_t rx_after;

	always_comb begin
		data_rd  = chipselect && read && (address == `REG_CHAR_TRANSFER);
		data_wr  = chipselect && write && (address == `REG_CHAR_TRANSFER);
		ctrl_wr  = chipselect && write && (address == `REG_IRQ_AND_FIFO_STATE);
		rx_pop   = data_rd && (s_q.rx_count != '0);
		rx_free  = count_t'(`FIFO_DEPTH - s_q.rx_count);
		tx_free  = count_t'(`FIFO_DEPTH - s_q.tx_count);
		rx_push  = host_in.valid && s_q.host_in_ready;
		tx_push  = data_wr && (tx_free != '0);
		// Output register holds one character; refill when empty or taken
		tx_pop   = (s_q.tx_count != '0) && (!s_q.host_out.valid || host_out_ready);
		rx_after = rx_pop ? count_t'(s_q.rx_count - 1'b1) : s_q.rx_count;
		// Conditions follow the registered counts, so a read clears them in the cycle after it
		rx_cond  = (rx_free <= `READ_THRESHOLD)
			|| ((s_q.rx_count != '0) && host_no_more);
		tx_cond  = (s_q.tx_count <= `WRITE_THRESHOLD);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (rx_push) begin
			s_d.rx_wr_ptr = s_q.rx_wr_ptr + 1'b1;
		end
		if (rx_pop) begin
			s_d.rx_rd_ptr = s_q.rx_rd_ptr + 1'b1;
		end
		s_d.rx_count = count_t'(s_q.rx_count + rx_push - rx_pop);
		// Ready follows the next count so a push never overfills
		s_d.host_in_ready = (s_d.rx_count < `FIFO_DEPTH);

		if (tx_push) begin
			s_d.tx_wr_ptr = s_q.tx_wr_ptr + 1'b1;
		end
		if (host_out_ready) begin
			s_d.host_out.valid = 1'b0;
		end
		if (tx_pop) begin
			s_d.tx_rd_ptr      = s_q.tx_rd_ptr + 1'b1;
			s_d.host_out.valid = 1'b1;
			s_d.host_out.data  = tx_mem[s_q.tx_rd_ptr];
		end
		s_d.tx_count = count_t'(s_q.tx_count + tx_push - tx_pop);

		if (ctrl_wr) begin
			s_d.rx_irq_enable = writedata[`RX_IRQ_EN_BIT];
			s_d.tx_irq_enable = writedata[`TX_IRQ_EN_BIT];
			if (writedata[`HOST_ACT_BIT]) begin
				s_d.host_activity_flag = 1'b0;
			end
		end
		// Set wins over a clear in the same cycle
		if (host_poll) begin
			s_d.host_activity_flag = 1'b1;
		end

		s_d.irq = (rx_cond && s_q.rx_irq_enable) || (tx_cond && s_q.tx_irq_enable);

		// Reserved bits read as zero
		s_d.readdata = '0;
		if (chipselect && read) begin
			if (address == `REG_CHAR_TRANSFER) begin
				s_d.readdata[`DATA_MSB:`DATA_LSB]          = rx_pop ? rx_mem[s_q.rx_rd_ptr] : 8'h00;
				s_d.readdata[`RX_VALID_BIT]                = rx_pop;
				s_d.readdata[`COUNT_LSB +: `FIFO_AW+1]     = rx_after;
			end else begin
				s_d.readdata[`RX_IRQ_EN_BIT]               = s_q.rx_irq_enable;
				s_d.readdata[`TX_IRQ_EN_BIT]               = s_q.tx_irq_enable;
				s_d.readdata[`RX_IRQ_PEND_BIT]             = rx_cond && s_q.rx_irq_enable;
				s_d.readdata[`TX_IRQ_PEND_BIT]             = tx_cond && s_q.tx_irq_enable;
				s_d.readdata[`HOST_ACT_BIT]                = s_q.host_activity_flag;
				s_d.readdata[`COUNT_LSB +: `FIFO_AW+1]     = tx_free;
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// Memories kept out of reset so they map to RAM
	always_ff @(posedge clk) begin
		if (rx_push) begin
			rx_mem[s_q.rx_wr_ptr] <= host_in.data;
		end
		if (tx_push) begin
			tx_mem[s_q.tx_wr_ptr] <= writedata[`DATA_MSB:`DATA_LSB];
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	always_comb begin
		readdata      = s_q.readdata;
		irq           = s_q.irq;
		host_out      = s_q.host_out;
		host_in_ready = s_q.host_in_ready;
	end

endmodule : jtag_char_port_regs

// >>> tb/jtag_char_port_checker.sv
// Pin-level assertions of the character port
`timescale 1ns/1ps
module jtag_char_port_checker
	import jtag_char_port_pkg::*;
(
	// Clock, reset, bus
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        address,
	input wire logic        chipselect,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] writedata,
	input wire logic [31:0] readdata,
	input wire logic        irq,
	// Host side
	input wire char_s       host_in,
	input wire logic        host_in_ready,
	input wire char_s       host_out,
	input wire logic        host_out_ready,
	input wire logic        host_poll,
	input wire logic        host_no_more
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire rd0 = chipselect && read && !address;
	wire rd1 = chipselect && read && address;
	wire wr1 = chipselect && write && address;
	// A poll near the clear would win, so none is allowed
	sequence ac_cleared;
		wr1 && writedata[10] && !host_poll ##1 !host_poll ##1 rd1 && !host_poll;
	endsequence
	sequence ac_raised;
		host_poll ##1 !wr1 ##1 rd1;
	endsequence
	a_idle_read_zero: assert property (!(chipselect && read) |=> readdata == 32'h0000_0000)
		else $error("readdata not idle");
	a_empty_read: assert property (rd0 |=> readdata[15] || readdata == 32'h0000_0000)
		else $error("empty read not clean");
	a_pend_gated: assert property (rd1 |=> (!readdata[8] || readdata[0]) && (!readdata[9] || readdata[1]))
		else $error("pending not gated");
	a_free_bound: assert property (rd1 |=> readdata[31:16] <= 16'h0040)
		else $error("free count too big");
	a_irq_off: assert property (wr1 && writedata[1:0] == 2'h0 ##1 !wr1 |=> !irq)
		else $error("irq without enable");
	a_ac_set: assert property (ac_raised |=> readdata[10])
		else $error("activity not set");
	a_ac_clear: assert property (ac_cleared |=> !readdata[10])
		else $error("activity not cleared");
	a_out_held: assert property (host_out.valid && !host_out_ready |=> host_out.valid && $stable(host_out.data))
		else $error("host_out not held");
endmodule : jtag_char_port_checker

bind jtag_char_port_regs jtag_char_port_checker u_jtag_char_port_checker (.*);

// >>> tb/host_link_model.sv
// Host end of the debug link
`timescale 1ns/1ps
module host_link_model
	import jtag_char_port_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       reset_n,
	// Bench control
	input  wire logic       send,
	input  wire logic [7:0] send_data,
	input  wire logic       stall,
	input  wire logic       poll,
	output logic [7:0]      last_q,
	output int              got_cnt,
	// Link
	output char_s           host_in,
	input  wire logic       host_in_ready,
	input  wire char_s      host_out,
	output logic            host_out_ready,
	output logic            host_poll
);
	// Idle data inverted so a stale char never passes
	assign host_in = '{send, send ? send_data : ~send_data};
	assign host_out_ready = !stall && reset_n;
	assign host_poll = poll;
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			got_cnt <= 0;
			last_q <= 8'h00;
		end else if (host_out.valid && host_out_ready) begin
			got_cnt <= got_cnt + 1;
			last_q <= host_out.data;
		end
	end
endmodule : host_link_model

// >>> tb/tb_jtag_char_port_regs.sv
// Self-checking bench of the character port
`timescale 1ns/1ps
module tb_jtag_char_port_regs import jtag_char_port_pkg::*; ;
	logic        clk = '0, reset_n = '0, address = '0, chipselect = '0, read = '0, write = '0;
	logic        send = '0, stall = '0, poll = '0, host_no_more = '0;
	logic [31:0] writedata = '0, readdata, d;
	logic [7:0]  send_data = '0, last_q;
	logic        irq, host_in_ready, host_out_ready, host_poll;
	char_s       host_in, host_out;
	int          got_cnt, error_cnt = 0, comparisons = 0;
	jtag_char_port_regs u_jtag_char_port_regs (.*);
	host_link_model u_host_link_model (.*);
	initial forever #10 clk = ~clk;
	task check(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("Error %s exp %h got %h", n, e, s);
		end
	endtask : check
	task bus(input logic w, a, input logic [31:0] v);
		@(posedge clk);
		{chipselect, read, write, address, writedata} <= {1'h1, !w, w, a, v};
		@(posedge clk);
		{chipselect, read, write} <= 3'h0;
		@(negedge clk);
		d = readdata;
	endtask : bus
	task rd(input logic a, input logic [31:0] e, input string n);
		bus(1'h0, a, 32'h0000_0000);
		check(n, d, e);
	endtask : rd
	task send_chars(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk) {send, send_data} <= {1'h1, 8'(i + 1)};
			@(posedge clk) send <= 1'h0;
		end
	endtask : send_chars
	task t_poll;
		rd(1'h1, 32'h0040_0000, "ctrl reset");
		@(posedge clk) poll <= 1'h1;
		@(posedge clk) poll <= 1'h0;
		rd(1'h1, 32'h0040_0400, "ac set");
		bus(1'h1, 1'h1, 32'h0000_0400);
		rd(1'h1, 32'h0040_0000, "ac clear");
		$display("t_poll done");
	endtask : t_poll
	task t_rx;
		rd(1'h0, 32'h0000_0000, "rx empty");
		send_chars(56);
		bus(1'h1, 1'h1, 32'h0000_0001);
		rd(1'h1, 32'h0040_0101, "rx high");
		check("irq rx", 32'(irq), 32'h0000_0001);
		rd(1'h0, 32'h0037_8001, "rx first");
		rd(1'h1, 32'h0040_0001, "rx below");
		for (int i = 2; i <= 56; i++) rd(1'h0, {16'(56 - i), 8'h80, 8'(i)}, "rx data");
		@(posedge clk) host_no_more <= 1'h1;
		send_chars(1);
		rd(1'h1, 32'h0040_0101, "rx last");
		rd(1'h0, 32'h0000_8001, "rx one");
		@(posedge clk) host_no_more <= 1'h0;
		bus(1'h1, 1'h1, 32'h0000_0000);
		$display("t_rx done");
	endtask : t_rx
	task t_tx;
		@(posedge clk) stall <= 1'h1;
		for (int i = 1; i <= 66; i++) bus(1'h1, 1'h0, 32'(i));
		bus(1'h1, 1'h1, 32'h0000_0002);
		rd(1'h1, 32'h0000_0002, "tx full");
		@(posedge clk) stall <= 1'h0;
		for (int i = 0; i < 400 && got_cnt < 65; i++) @(posedge clk);
		check("tx count", 32'(got_cnt), 32'h0000_0041);
		check("tx last", 32'(last_q), 32'h0000_0041);
		rd(1'h1, 32'h0040_0202, "tx empty");
		check("irq tx", 32'(irq), 32'h0000_0001);
		bus(1'h1, 1'h1, 32'h0000_0000);
		$display("t_tx done");
	endtask : t_tx
	task close_out;
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : close_out
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'h1;
		t_poll;
		t_rx;
		t_tx;
		close_out;
	end
	// Whole run is near 470 cycles
	initial begin
		#400_000;
		error_cnt++;
		close_out;
	end
endmodule : tb_jtag_char_port_regs
